//--- hdl/dcf_fifo.sv
// Deep FIFO with write and read link clocks sampled by one system clock, plus its staging FIFO.
// Assumes link clocks are far slower than clk and that dcf_pkg is compiled first.
`timescale 1ns/1ps
`include "dcf_params.svh"

// Small staging FIFO between the write link and the main array.
module dcf_stage #(
	parameter int WIDTH = `DCF_WIDTH,
	parameter int DEPTH = `DCF_STAGE_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0] lvl_reg, lvl_next;
	logic push, pop;

	// Honest full and empty from the level; a stalled drain lets it fill.
	always_comb
	begin
		in_ready = (lvl_reg != (AW+1)'(DEPTH));
		out_valid = (lvl_reg != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_next = push ? wp_reg + AW'(1) : wp_reg;
		rp_next = pop ? rp_reg + AW'(1) : rp_reg;
		lvl_next = lvl_reg + (AW+1)'(push) - (AW+1)'(pop);
		out_data = mem[rp_reg];
		level = lvl_reg;
	end

	// Pointer and storage registers.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			lvl_reg <= '0;
		end
		else
		begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			lvl_reg <= lvl_next;
		end
		if (push)
			mem[wp_reg] <= in_data;
	end
endmodule : dcf_stage

// Top: deep FIFO with flags, offset register and depth cascading.
module dcf_fifo (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic large_variant,
	input wire logic wr_clk,
	input wire logic wr_en_n,
	input wire logic [`DCF_WIDTH-1:0] wr_data,
	input wire logic rd_clk,
	input wire logic rd_en_n,
	input wire logic out_drive_en,
	input wire logic offset_load_sel,
	input wire logic flag_sync_select,
	input wire logic depth_chain_en,
	input wire logic first_in_chain,
	input wire logic write_chain_in,
	input wire logic read_chain_in,
	output logic [`DCF_WIDTH-1:0] rd_data,
	output logic data_oe_n,
	output logic empty_flag_n,
	output logic full_flag_n,
	output logic almost_empty_flag_n,
	output logic almost_full_flag_n,
	output logic half_full_flag,
	output logic read_chain_out_n
);
	// Every link input passes two flip-flops; the third stage only feeds edge detection.
	logic [`DCF_SYNC_W-1:0] s1_reg, s2_reg;
	logic [`DCF_SYNC_W-1:0] sync_in;
	logic wclk_d_reg, rclk_d_reg, wci_d_reg, rci_d_reg;
	logic wclk_s, rclk_s, wen_s_n, ren_s_n, ld_s_n, fl_s, wci_s, rci_s;
	dcf_pkg::dcf_word_t din_s;
	logic wr_edge, rd_edge, wci_rise, rci_fall;

	assign sync_in = {wr_clk, rd_clk, wr_en_n, rd_en_n, offset_load_sel,
		first_in_chain, write_chain_in, read_chain_in, 1'b0, wr_data};
	assign {wclk_s, rclk_s, wen_s_n, ren_s_n, ld_s_n, fl_s, wci_s, rci_s} =
		s2_reg[`DCF_SYNC_W-1:`DCF_WIDTH+1];
	assign din_s = s2_reg[`DCF_WIDTH-1:0];
	assign wr_edge = wclk_s && !wclk_d_reg;
	assign rd_edge = rclk_s && !rclk_d_reg;
	assign wci_rise = wci_s && !wci_d_reg;
	assign rci_fall = !rci_s && rci_d_reg;

	// Synchroniser and edge-detect registers.
	always_ff @(posedge clk)
	begin
		s1_reg <= sync_in;
		s2_reg <= s1_reg;
		wclk_d_reg <= wclk_s;
		rclk_d_reg <= rclk_s;
		wci_d_reg <= wci_s;
		rci_d_reg <= rci_s;
	end

	// Fill level arithmetic used by several flags.
	function automatic logic at_least(input dcf_pkg::dcf_cnt_t cnt, input dcf_pkg::dcf_cnt_t lim);
		at_least = (cnt >= lim);
	endfunction : at_least

	// Main storage and its control state.
	dcf_pkg::dcf_word_t mem [`DCF_DEPTH_LARGE];
	logic [`DCF_ADDR_W-1:0] wa_reg, wa_next, ra_reg, ra_next;
	dcf_pkg::dcf_cnt_t mcnt_reg, mcnt_next, total, depth, half;
	dcf_pkg::dcf_word_t ae_off_reg, ae_off_next, af_off_reg, af_off_next;
	dcf_pkg::dcf_word_t q_reg, q_next;
	dcf_pkg::dcf_off_sel_t owsel_reg, owsel_next, orsel_reg, orsel_next;
	logic ef_reg, ef_next, ff_reg, ff_next, ae_reg, ae_next, af_reg, af_next;
	logic hf_reg, hf_next, oe_reg, oe_next, rco_reg, rco_next;
	logic wtok_reg, wtok_next, rtok_reg, rtok_next, init_reg, init_next;
	logic stg_ready, stg_valid, drain, wr_take, rd_take;
	logic [$clog2(`DCF_STAGE_DEPTH):0] stg_level;
	dcf_pkg::dcf_word_t stg_data;
	dcf_pkg::dcf_cnt_t total_after;
	logic ae_now, af_now;

	// Writes land in the staging FIFO; its drain stalls when the array is full.
	dcf_stage #(
		.WIDTH(`DCF_WIDTH),
		.DEPTH(`DCF_STAGE_DEPTH)
	) u_stage (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_data(din_s),
		.in_valid(wr_take),
		.in_ready(stg_ready),
		.out_data(stg_data),
		.out_valid(stg_valid),
		.out_ready(drain),
		.level(stg_level)
	);

	// Next-state logic for pointers, counts, offsets, flags and chain tokens.
	always_comb
	begin
		depth = large_variant ? `DCF_DEPTH_LARGE : `DCF_DEPTH_SMALL;
		half = large_variant ? `DCF_HALF_LARGE : `DCF_HALF_SMALL;
		total = mcnt_reg + `DCF_CNT_W'(stg_level);
		drain = stg_valid && (mcnt_reg < depth);
		// Writes are accepted every edge while enabled and offset loading is off, unless full or the token is elsewhere.
		wr_take = wr_edge && !wen_s_n && ld_s_n && (total < depth) && stg_ready
			&& (wtok_reg || !depth_chain_en);
		rd_take = rd_edge && !ren_s_n && ld_s_n && (mcnt_reg != '0)
			&& (rtok_reg || !depth_chain_en);
		wa_next = drain ? wa_reg + `DCF_ADDR_W'(1) : wa_reg;
		ra_next = rd_take ? ra_reg + `DCF_ADDR_W'(1) : ra_reg;
		mcnt_next = mcnt_reg + `DCF_CNT_W'(drain) - `DCF_CNT_W'(rd_take);
		total_after = total + `DCF_CNT_W'(wr_take) - `DCF_CNT_W'(rd_take);
		q_next = rd_take ? mem[ra_reg] : q_reg;
		ae_off_next = ae_off_reg;
		af_off_next = af_off_reg;
		owsel_next = owsel_reg;
		orsel_next = orsel_reg;
		// Offset register: writes alternate empty then full offset, reads likewise.
		if (wr_edge && !wen_s_n && !ld_s_n)
		begin
			if (owsel_reg == dcf_pkg::DCF_OFF_EMPTY)
				ae_off_next = din_s;
			else
				af_off_next = din_s;
			owsel_next = (owsel_reg == dcf_pkg::DCF_OFF_EMPTY) ? dcf_pkg::DCF_OFF_FULL
				: dcf_pkg::DCF_OFF_EMPTY;
		end
		if (rd_edge && !ren_s_n && !ld_s_n)
		begin
			q_next = (orsel_reg == dcf_pkg::DCF_OFF_EMPTY) ? ae_off_reg : af_off_reg;
			orsel_next = (orsel_reg == dcf_pkg::DCF_OFF_EMPTY) ? dcf_pkg::DCF_OFF_FULL
				: dcf_pkg::DCF_OFF_EMPTY;
		end
		// Empty moves only on read edges and full only on write edges, both active low.
		ef_next = rd_edge ? (mcnt_next != '0) : ef_reg;
		ff_next = wr_edge ? (total_after < depth) : ff_reg;
		ae_now = !at_least(total_after, `DCF_CNT_W'(ae_off_reg) + `DCF_CNT_W'(1));
		af_now = at_least(total_after, depth - `DCF_CNT_W'(af_off_reg));
		// Almost flags follow every clk when flag_sync_select is high, else only their own edges.
		if (flag_sync_select)
		begin
			ae_next = !ae_now;
			af_next = !af_now;
		end
		else
		begin
			ae_next = rd_edge ? !ae_now : ae_reg;
			af_next = wr_edge ? !af_now : af_reg;
		end
		oe_next = !out_drive_en;
		init_next = 1'b0;
		wtok_next = wtok_reg;
		rtok_next = rtok_reg;
		rco_next = rco_reg;
		// The first-in-chain strap is caught one cycle after reset release.
		if (init_reg)
		begin
			wtok_next = !fl_s;
			rtok_next = !fl_s;
		end
		else if (depth_chain_en)
		begin
			// Filling passes the write token; draining dry passes the read token.
			if (wr_take && (total_after == depth))
				wtok_next = 1'b0;
			else if (wci_rise)
				wtok_next = 1'b1;
			if (rd_take && (mcnt_next == '0) && (stg_level == '0))
			begin
				rtok_next = 1'b0;
				rco_next = 1'b0;
			end
			else if (rd_edge)
				rco_next = 1'b1;
			if (rci_fall)
				rtok_next = 1'b1;
		end
		else
			rco_next = 1'b1;
		// Shared pin: half full alone, a one link cycle pulse as token passes in a chain.
		if (!depth_chain_en)
			hf_next = !(total_after > half);
		else if (wr_take && (total_after == depth))
			hf_next = 1'b1;
		else if (wr_edge)
			hf_next = 1'b0;
		else
			hf_next = hf_reg;
	end

	// State registers; reset leaves the FIFO empty with both flags showing it.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wa_reg <= '0;
			ra_reg <= '0;
			mcnt_reg <= '0;
			ae_off_reg <= `DCF_AE_OFF_RST;
			af_off_reg <= `DCF_AF_OFF_RST;
			owsel_reg <= dcf_pkg::DCF_OFF_EMPTY;
			orsel_reg <= dcf_pkg::DCF_OFF_EMPTY;
			q_reg <= '0;
			ef_reg <= 1'b0;
			ff_reg <= 1'b1;
			ae_reg <= 1'b0;
			af_reg <= 1'b1;
			hf_reg <= 1'b1;
			oe_reg <= 1'b1;
			rco_reg <= 1'b1;
			wtok_reg <= 1'b0;
			rtok_reg <= 1'b0;
			init_reg <= 1'b1;
		end
		else
		begin
			wa_reg <= wa_next;
			ra_reg <= ra_next;
			mcnt_reg <= mcnt_next;
			ae_off_reg <= ae_off_next;
			af_off_reg <= af_off_next;
			owsel_reg <= owsel_next;
			orsel_reg <= orsel_next;
			q_reg <= q_next;
			ef_reg <= ef_next;
			ff_reg <= ff_next;
			ae_reg <= ae_next;
			af_reg <= af_next;
			hf_reg <= hf_next;
			oe_reg <= oe_next;
			rco_reg <= rco_next;
			wtok_reg <= wtok_next;
			rtok_reg <= rtok_next;
			init_reg <= init_next;
		end
	end

	// Array write port, fed from the staging FIFO.
	always_ff @(posedge clk)
	begin
		if (drain)
			mem[wa_reg] <= stg_data;
	end

	// Outputs come straight from registers; the enable only gates the pads.
	assign rd_data = q_reg;
	assign data_oe_n = oe_reg;
	assign empty_flag_n = ef_reg;
	assign full_flag_n = ff_reg;
	assign almost_empty_flag_n = ae_reg;
	assign almost_full_flag_n = af_reg;
	assign half_full_flag = hf_reg;
	assign read_chain_out_n = rco_reg;
endmodule : dcf_fifo

//--- hdl/dcf_params.svh
// Constants for the deep dual-clock FIFO: depths, widths, reset values and synchroniser width.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH
`define DCF_WIDTH 18
`define DCF_DEPTH_SMALL 16'h2000
`define DCF_DEPTH_LARGE 16'h4000
`define DCF_ADDR_W 14
`define DCF_CNT_W 16
`define DCF_HALF_LARGE 16'h2000
`define DCF_HALF_SMALL 16'h1000
`define DCF_AE_OFF_RST 18'h0007f
`define DCF_AF_OFF_RST 18'h0007f
`define DCF_STAGE_DEPTH 32
`define DCF_SYNC_W 27
`endif

//--- hdl/dcf_pkg.sv
// Types shared by the deep dual-clock FIFO design.
// Assumes dcf_params.svh is on the include path.
`include "dcf_params.svh"
package dcf_pkg;
	typedef logic [`DCF_WIDTH-1:0] dcf_word_t;
	typedef logic [`DCF_CNT_W-1:0] dcf_cnt_t;
	typedef enum logic {DCF_OFF_EMPTY, DCF_OFF_FULL} dcf_off_sel_t;
endpackage : dcf_pkg

//--- sim/dcf_fifo_assertions.sv
// Checker on the deep FIFO's ports: flag domains, flag stability and output enable.
// Assumes link clocks run at 8 clk or more a period and are sampled by clk.
`timescale 1ns/1ps
`include "dcf_params.svh"
module dcf_fifo_assertions (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wr_clk,
	input wire logic rd_clk,
	input wire logic out_drive_en,
	input wire logic depth_chain_en,
	input wire logic [`DCF_WIDTH-1:0] rd_data,
	input wire logic data_oe_n,
	input wire logic empty_flag_n,
	input wire logic full_flag_n,
	input wire logic almost_full_flag_n,
	input wire logic read_chain_out_n
);
	logic [1:0] wq_reg, rq_reg;
	logic [3:0] wage_reg, rage_reg;
	// Count cycles since each link clock was last seen rising, saturating at 15.
	always_ff @(posedge clk)
	begin
		wq_reg <= {wq_reg[0], wr_clk};
		rq_reg <= {rq_reg[0], rd_clk};
		wage_reg <= sys_rst ? 4'hf : (wq_reg == 2'b01 ? 4'h0 : wage_reg + {3'h0, wage_reg != 4'hf});
		rage_reg <= sys_rst ? 4'hf : (rq_reg == 2'b01 ? 4'h0 : rage_reg + {3'h0, rage_reg != 4'hf});
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_full_held;
		!full_flag_n [*2];
	endsequence
	a_empty_rd_side: assert property ($changed(empty_flag_n) |-> rage_reg <= 4'h4)
		else $error("empty flag moved away from a read clock edge");
	a_full_wr_side: assert property ($changed(full_flag_n) |-> wage_reg <= 4'h4)
		else $error("full flag moved away from a write clock edge");
	a_empty_steady: assert property ($rose(empty_flag_n) |=> empty_flag_n [*5])
		else $error("empty flag bounced");
	a_full_steady: assert property ($fell(full_flag_n) |=> !full_flag_n [*5])
		else $error("full flag bounced");
	a_flags_exclusive: assert property (!(!empty_flag_n && !full_flag_n))
		else $error("empty and full both shown");
	a_full_almost: assert property (s_full_held |-> !almost_full_flag_n)
		else $error("full without almost full");
	a_data_on_read: assert property ($changed(rd_data) |-> rage_reg <= 4'h4)
		else $error("read data moved without a read clock edge");
	a_oe_follows: assert property (1'b1 |=> data_oe_n == !$past(out_drive_en))
		else $error("output enable did not follow");
	a_chain_quiet: assert property (!depth_chain_en |-> read_chain_out_n)
		else $error("chain output pulsed outside cascade mode");
endmodule : dcf_fifo_assertions
bind dcf_fifo dcf_fifo_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .wr_clk(wr_clk),
	.rd_clk(rd_clk), .out_drive_en(out_drive_en), .depth_chain_en(depth_chain_en),
	.rd_data(rd_data), .data_oe_n(data_oe_n), .empty_flag_n(empty_flag_n),
	.full_flag_n(full_flag_n), .almost_full_flag_n(almost_full_flag_n),
	.read_chain_out_n(read_chain_out_n));

//--- sim/dcf_fifo_tb.sv
// Self-checking bench for the deep FIFO: order, flags, offset register and output enable.
// Assumes dcf_link_model drives the link side; the bench sets depth, straps and the chain ring.
`timescale 1ns/1ps
module dcf_fifo_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic out_drive_en = 1'b1;
	logic offset_load_sel = 1'b1;
	logic flag_sync_select = 1'b1;
	logic large_variant = 1'b0;
	logic depth_chain_en = 1'b0;
	logic first_in_chain = 1'b0;
	logic write_chain_in;
	logic read_chain_in;
	logic wr_clk, wr_en_n, rd_clk, rd_en_n, data_oe_n, empty_flag_n, full_flag_n;
	logic almost_empty_flag_n, almost_full_flag_n, half_full_flag, read_chain_out_n;
	logic [17:0] wr_data, rd_data;
	int err_total = 0;
	int check_count = 0;
	int rco_low_cnt = 0;
	dcf_link_model link (
		.wr_clk(wr_clk),
		.wr_en_n(wr_en_n),
		.wr_data(wr_data),
		.rd_clk(rd_clk),
		.rd_en_n(rd_en_n)
	);
	// One device; the scenarios set its depth, its strap and its chain ring.
	dcf_fifo dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.large_variant(large_variant),
		.wr_clk(wr_clk),
		.wr_en_n(wr_en_n),
		.wr_data(wr_data),
		.rd_clk(rd_clk),
		.rd_en_n(rd_en_n),
		.out_drive_en(out_drive_en),
		.offset_load_sel(offset_load_sel),
		.flag_sync_select(flag_sync_select),
		.depth_chain_en(depth_chain_en),
		.first_in_chain(first_in_chain),
		.write_chain_in(write_chain_in),
		.read_chain_in(read_chain_in),
		.rd_data(rd_data),
		.data_oe_n(data_oe_n),
		.empty_flag_n(empty_flag_n),
		.full_flag_n(full_flag_n),
		.almost_empty_flag_n(almost_empty_flag_n),
		.almost_full_flag_n(almost_full_flag_n),
		.half_full_flag(half_full_flag),
		.read_chain_out_n(read_chain_out_n)
	);
	// The 40 MHz system clock.
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	// A ring of one device: in cascade its chain outputs return to its own chain inputs.
	always @(negedge clk)
	begin
		write_chain_in <= depth_chain_en && half_full_flag;
		read_chain_in <= !depth_chain_en || read_chain_out_n;
		rco_low_cnt <= rco_low_cnt + ((read_chain_out_n === 1'b0) ? 1 : 0);
	end
	task automatic chkn(input int got, input int exp);
		check_count++;
		if (got != exp)
		begin
			err_total++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chkn
	task automatic chkw(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chkw
	task automatic chkb(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chkb
	task automatic settle;
		repeat (16) @(negedge clk);
	endtask : settle
	task automatic do_reset;
		sys_rst = 1'b1;
		repeat (5) @(negedge clk);
		chkb(empty_flag_n, 1'b0);
		chkb(full_flag_n, 1'b1);
		chkb(half_full_flag, 1'b1);
		chkb(almost_full_flag_n, 1'b1);
		chkw(rd_data, 18'h00000);
		chkb(almost_empty_flag_n, 1'b0);
		chkb(data_oe_n, 1'b1);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask : do_reset
	task automatic t_stream;
		link.push(4, 18'h3fff0);
		settle;
		chkb(empty_flag_n, 1'b1);
		link.pull(3);
		settle;
		chkw(rd_data, 18'h3fff2);
		link.pull(1);
		settle;
		chkw(rd_data, 18'h3fff3);
		chkb(empty_flag_n, 1'b0);
		link.pull(1);
		settle;
		chkw(rd_data, 18'h3fff3);
	endtask : t_stream
	task automatic t_offset;
		offset_load_sel = 1'b0;
		settle;
		link.push(2, 18'h00002);
		link.pull(2);
		settle;
		chkw(rd_data, 18'h00003);
		offset_load_sel = 1'b1;
		flag_sync_select = 1'b0;
		settle;
		link.push(2, 18'h00100);
		settle;
		chkb(almost_empty_flag_n, 1'b0);
		link.push(1, 18'h00102);
		settle;
		chkb(almost_empty_flag_n, 1'b1);
		link.pull(3);
		settle;
		chkw(rd_data, 18'h00102);
	endtask : t_offset
	task automatic t_oe;
		out_drive_en = 1'b0;
		link.push(1, 18'h2aaaa);
		link.pull(1);
		settle;
		chkb(data_oe_n, 1'b1);
		out_drive_en = 1'b1;
		settle;
		chkb(data_oe_n, 1'b0);
		chkw(rd_data, 18'h2aaaa);
	endtask : t_oe
	task automatic t_fill;
		do_reset;
		link.push(4096, 18'h00000);
		settle;
		chkb(half_full_flag, 1'b1);
		link.push(1, 18'h01000);
		settle;
		chkb(half_full_flag, 1'b0);
		link.push(3967, 18'h01001);
		settle;
		chkb(almost_full_flag_n, 1'b1);
		link.push(128, 18'h01f80);
		settle;
		chkb(full_flag_n, 1'b0);
		link.push(1, 18'h3ffff);
		link.pull(1);
		settle;
		chkw(rd_data, 18'h00000);
		chkb(full_flag_n, 1'b1);
	endtask : t_fill
	// Cascade ring of one: the strap decides who holds the tokens, the ring hands the read token back.
	task automatic t_chain;
		int rco_base;
		depth_chain_en = 1'b1;
		first_in_chain = 1'b1;
		do_reset;
		link.push(1, 18'h00abc);
		settle;
		chkb(empty_flag_n, 1'b0);
		first_in_chain = 1'b0;
		do_reset;
		link.push(2, 18'h00ab0);
		settle;
		chkb(empty_flag_n, 1'b1);
		rco_base = rco_low_cnt;
		link.pull(2);
		settle;
		chkw(rd_data, 18'h00ab1);
		chkn(rco_low_cnt - rco_base, 8);
		link.push(1, 18'h00ab2);
		settle;
		link.pull(1);
		settle;
		chkw(rd_data, 18'h00ab2);
		depth_chain_en = 1'b0;
	endtask : t_chain
	// The larger depth moves the almost-full threshold loaded through the offset register.
	task automatic t_large;
		large_variant = 1'b1;
		do_reset;
		offset_load_sel = 1'b0;
		settle;
		link.push(2, 18'h03ffb);
		settle;
		offset_load_sel = 1'b1;
		settle;
		link.push(3, 18'h00200);
		settle;
		chkb(almost_full_flag_n, 1'b1);
		link.push(1, 18'h00203);
		settle;
		chkb(almost_full_flag_n, 1'b0);
		chkb(almost_empty_flag_n, 1'b0);
		large_variant = 1'b0;
		do_reset;
	endtask : t_large
	task automatic summarize;
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	// Main sequence, driven off the falling edge of clk.
	initial
	begin
		@(negedge clk);
		do_reset;
		t_stream;
		t_offset;
		t_oe;
		t_chain;
		t_large;
		t_fill;
		summarize;
	end
	// Watchdog sized for the fill of the small 8192-word depth plus margin.
	initial
	begin
		#2200000;
		err_total++;
		summarize;
	end
endmodule : dcf_fifo_tb

//--- sim/dcf_link_model.sv
// Link-side model: free-running write and read clocks with their enables and data.
// Assumes the bench calls push and pull one at a time.
`timescale 1ns/1ps
module dcf_link_model (
	output logic wr_clk,
	output logic wr_en_n,
	output logic [17:0] wr_data,
	output logic rd_clk,
	output logic rd_en_n
);
	// Both link clocks run free at 200 ns, out of phase with clk and each other.
	initial
	begin
		wr_clk = 1'b0;
		rd_clk = 1'b0;
		wr_en_n = 1'b1;
		rd_en_n = 1'b1;
		wr_data = 18'h15555;
		fork
			#7 forever #100 wr_clk = ~wr_clk;
			#61 forever #100 rd_clk = ~rd_clk;
		join
	end
	// Writes n words counting up from base, enable held low throughout.
	task automatic push(input int n, input logic [17:0] base);
		@(negedge wr_clk);
		wr_en_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			wr_data = base + 18'(i);
			@(negedge wr_clk);
		end
		wr_en_n = 1'b1;
		wr_data = ~wr_data;
	endtask : push
	// Reads n words back to back.
	task automatic pull(input int n);
		@(negedge rd_clk);
		rd_en_n = 1'b0;
		repeat (n) @(negedge rd_clk);
		rd_en_n = 1'b1;
	endtask : pull
endmodule : dcf_link_model
